// ==== inc/eng_pkg.sv ====
package eng_pkg;

   // Clock rates; the engine tick is derived from the system clock
   localparam int CLK_HZ     = 125_000_000;
   localparam int MASTER_HZ  = 32768;
   localparam int MASTER_DIV = CLK_HZ / MASTER_HZ;

   // Instruction timing in engine ticks
   localparam logic [13:0] SET_TICKS   = 14'h0010;
   localparam int          PRE_FAST_SH = 4;    // Divide by 16
   localparam int          PRE_SLOW_SH = 9;    // Divide by 512

   // Operand field positions
   localparam int TYPE_BIT     = 14;
   localparam int SIGN_BIT     = 8;
   localparam int WAIT_PRE_BIT = 14;
   localparam int WAIT_T_HI    = 13;
   localparam int WAIT_T_LO    = 9;

   // Output bank
   localparam int         NUM_OUT = 11;
   localparam int         ADDR_W  = 7;
   localparam logic [7:0] LVL_MAX = 8'hFF;
   localparam logic [7:0] LVL_RST = 8'h00;
   localparam logic [6:0] PTR_RST = 7'h00;

   // Decoded instruction presented to the engine
   typedef enum logic [3:0] {
      cmd_set_level,
      cmd_set_var,
      cmd_wait,
      table_first_op,
      table_last_op,
      cmd_select,
      cmd_clear,
      cmd_step_fwd,
      cmd_step_back,
      cmd_set_row
   } cmd_t;

   typedef enum logic [2:0] {
      st_idle,
      st_fetch,
      st_load,
      st_set,
      st_wait
   } state_t;

endpackage

// ==== inc/level_if.sv ====
`timescale 1ns/10ps
interface level_if;
   logic                       apply;
   logic                       absolute;
   logic                       decrease;
   logic [7:0]                 value;
   logic [eng_pkg::NUM_OUT-1:0] mask;

   modport src  (output apply, output absolute, output decrease,
                 output value, output mask);
   modport bank (input apply, input absolute, input decrease,
                 input value, input mask);
endinterface

// ==== hw/tick_gen.sv ====
`timescale 1ns/10ps
module tick_gen #(
   parameter int DIV = eng_pkg::MASTER_DIV
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic restart,
   output logic      tick
);
   localparam int W = $clog2(DIV);

   logic [W-1:0] div_cnt;
   logic [W-1:0] next_div_cnt;
   logic         next_tick;

   // Restart realigns the phase so a timed op gets whole tick periods
   always_comb begin
      next_div_cnt = div_cnt + W'(1);
      next_tick    = 1'b0;
      if (restart) begin
         next_div_cnt = '0;
      end else if (div_cnt == W'(DIV - 1)) begin
         next_div_cnt = '0;
         next_tick    = 1'b1;
      end
   end

   // Registered so the tick is a clean one-cycle pulse
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt <= '0;
         tick    <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         tick    <= next_tick;
      end
   end
endmodule

// ==== hw/level_bank.sv ====
`timescale 1ns/10ps
module level_bank #(
   parameter int N = eng_pkg::NUM_OUT
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   level_if.bank             lv,
   output logic [8*N-1:0]    level_out
);
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_out
         logic [7:0] lvl;
         logic [7:0] next_lvl;
         logic [8:0] sum;

         // Only mapped outputs move; unmapped ones keep their own level
         always_comb begin
            sum      = {1'b0, lvl} + {1'b0, lv.value};
            next_lvl = lvl;
            if (lv.apply && lv.mask[i]) begin
               if (lv.absolute) begin
                  next_lvl = lv.value;
               end else if (lv.decrease) begin
                  // Clamp at zero rather than wrap to full scale
                  next_lvl = (lvl > lv.value) ? lvl - lv.value : 8'h00;
               end else begin
                  next_lvl = sum[8] ? eng_pkg::LVL_MAX : sum[7:0];
               end
            end
         end

         always_ff @(posedge sys_clk) begin
            if (rst) begin
               lvl <= eng_pkg::LVL_RST;
            end else begin
               lvl <= next_lvl;
            end
         end

         assign level_out[8*i +: 8] = lvl;
      end
   endgenerate
endmodule

// ==== hw/engine_brightness_and_mapping.sv ====
`timescale 1ns/10ps
module engine_brightness_and_mapping (
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        op_valid,
   input  wire eng_pkg::cmd_t               op_cmd,
   input  wire logic [15:0]                 op_arg,
   input  wire logic [7:0]                  var_a,
   input  wire logic [7:0]                  var_b,
   input  wire logic [7:0]                  var_c,
   input  wire logic [7:0]                  var_d,
   input  wire logic [15:0]                 mem_data,
   output logic [eng_pkg::ADDR_W-1:0]       mem_addr,
   output logic                             mem_rd,
   output logic                             busy,
   output logic                             waiting,
   output logic [eng_pkg::NUM_OUT-1:0]      active_mask,
   output logic [eng_pkg::ADDR_W-1:0]       table_first,
   output logic [eng_pkg::ADDR_W-1:0]       table_last,
   output logic [8*eng_pkg::NUM_OUT-1:0]    level_out
);
   localparam int N = eng_pkg::NUM_OUT;
   localparam int A = eng_pkg::ADDR_W;

   eng_pkg::state_t state;
   eng_pkg::state_t next_state;
   logic [13:0]     cnt;
   logic [13:0]     next_cnt;
   logic [A-1:0]    row_ptr;
   logic [A-1:0]    next_ptr;
   logic [A-1:0]    next_first;
   logic [A-1:0]    next_last;
   logic [N-1:0]    next_mask;
   logic            accept;
   logic            accept_set;
   logic            timed_start;
   logic            tick;
   logic [4:0]      t_field;
   logic [13:0]     wait_ticks;
   logic [N-1:0]    sel_mask;
   logic [3:0]      sel;
   logic [7:0]      var_value;

   level_if lv ();

   // Ops are taken only while idle; busy tells the sequencer to hold off
   assign accept     = op_valid && (state == eng_pkg::st_idle);
   assign accept_set = accept && (op_cmd == eng_pkg::cmd_set_level ||
                                  op_cmd == eng_pkg::cmd_set_var);
   assign timed_start = accept_set || (accept && op_cmd == eng_pkg::cmd_wait);

   // Operand decode for wait, single-select and the variable source
   always_comb begin
      t_field = op_arg[eng_pkg::WAIT_T_HI:eng_pkg::WAIT_T_LO];
      // A zero time field counts as one, so the op still waits 16 or 512 ticks and cannot stall
      if (t_field == 5'h00) begin
         t_field = 5'h01;
      end
      if (op_arg[eng_pkg::WAIT_PRE_BIT]) begin
         wait_ticks = 14'(t_field) << eng_pkg::PRE_SLOW_SH;
      end else begin
         wait_ticks = 14'(t_field) << eng_pkg::PRE_FAST_SH;
      end
      sel      = op_arg[3:0];
      sel_mask = '0;
      if (sel != 4'h0 && sel <= 4'(N)) begin
         sel_mask = N'(1) << (sel - 4'h1);
      end
      case (op_arg[1:0])
         2'h0:    var_value = var_a;
         2'h1:    var_value = var_b;
         2'h2:    var_value = var_c;
         default: var_value = var_d;
      endcase
   end

   // Level command to the bank; fires in the accepting cycle only
   always_comb begin
      lv.apply    = accept_set;
      lv.absolute = op_arg[eng_pkg::TYPE_BIT];
      lv.decrease = op_arg[eng_pkg::SIGN_BIT];
      lv.value    = (op_cmd == eng_pkg::cmd_set_var) ? var_value
                                                     : op_arg[7:0];
      lv.mask     = active_mask;
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_ptr   = row_ptr;
      next_first = table_first;
      next_last  = table_last;
      next_mask  = active_mask;
      case (state)
         eng_pkg::st_idle: begin
            if (op_valid) begin
               case (op_cmd)
                  eng_pkg::cmd_set_level,
                  eng_pkg::cmd_set_var: begin
                     next_state = eng_pkg::st_set;
                     next_cnt   = eng_pkg::SET_TICKS;
                  end
                  eng_pkg::cmd_wait: begin
                     next_state = eng_pkg::st_wait;
                     next_cnt   = wait_ticks;
                  end
                  eng_pkg::table_first_op: begin
                     next_first = op_arg[A-1:0];
                  end
                  eng_pkg::table_last_op: begin
                     next_last = op_arg[A-1:0];
                  end
                  eng_pkg::cmd_select: begin
                     next_mask = sel_mask;
                  end
                  eng_pkg::cmd_clear: begin
                     next_mask = '0;
                  end
                  eng_pkg::cmd_step_fwd: begin
                     next_ptr   = (row_ptr == table_last) ? table_first
                                  : row_ptr + A'(1);
                     next_state = eng_pkg::st_fetch;
                  end
                  eng_pkg::cmd_step_back: begin
                     next_ptr   = (row_ptr == table_first) ? table_last
                                  : row_ptr - A'(1);
                     next_state = eng_pkg::st_fetch;
                  end
                  eng_pkg::cmd_set_row: begin
                     next_ptr   = op_arg[A-1:0];
                     next_state = eng_pkg::st_fetch;
                  end
                  default: begin
                     next_state = eng_pkg::st_idle;
                  end
               endcase
            end
         end
         eng_pkg::st_fetch: begin
            next_state = eng_pkg::st_load;
         end
         eng_pkg::st_load: begin
            // The row is a mask and nothing else; levels are left alone
            next_mask  = mem_data[N-1:0];
            next_state = eng_pkg::st_idle;
         end
         eng_pkg::st_set,
         eng_pkg::st_wait: begin
            if (tick) begin
               next_cnt = cnt - 14'h0001;
               if (cnt == 14'h0001) begin
                  next_state = eng_pkg::st_idle;
               end
            end
         end
         default: begin
            next_state = eng_pkg::st_idle;
         end
      endcase
   end

   // Sequencer registers; status outputs decode next_state so they line up with state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state       <= eng_pkg::st_idle;
         cnt         <= '0;
         row_ptr     <= eng_pkg::PTR_RST;
         table_first <= eng_pkg::PTR_RST;
         table_last  <= eng_pkg::PTR_RST;
         active_mask <= '0;
         busy        <= 1'b0;
         waiting     <= 1'b0;
         mem_rd      <= 1'b0;
      end else begin
         state       <= next_state;
         cnt         <= next_cnt;
         row_ptr     <= next_ptr;
         table_first <= next_first;
         table_last  <= next_last;
         active_mask <= next_mask;
         busy        <= (next_state != eng_pkg::st_idle);
         waiting     <= (next_state == eng_pkg::st_wait);
         mem_rd      <= (next_state == eng_pkg::st_fetch);
      end
   end

   assign mem_addr = row_ptr;

   tick_gen #(
      .DIV     (eng_pkg::MASTER_DIV)
   ) u_tick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .restart (timed_start),
      .tick    (tick)
   );

   level_bank #(
      .N         (N)
   ) u_bank (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .lv        (lv),
      .level_out (level_out)
   );

   // Helper: ticks spent in the current timed op and its loaded length
   logic [13:0] elapsed;
   logic [13:0] span;
   always_ff @(posedge sys_clk) begin
      if (rst || timed_start) begin
         elapsed <= '0;
         span    <= timed_start ? next_cnt : 14'h0000;
      end else if (tick) begin
         elapsed <= elapsed + 14'h0001;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // Output two is watched: directed table rows ROW_1 and ROW_2 map it, ROW_0 does not
   abs_load_a: assert property (
      accept_set && op_arg[eng_pkg::TYPE_BIT] && active_mask[1] &&
      op_cmd == eng_pkg::cmd_set_level
      |=> level_out[15:8] == $past(op_arg[7:0]))
      else $error("absolute set did not load mapped output");
   direct_set_a: assert property (
      accept_set |=> (busy && state == eng_pkg::st_set)
      ##1 $stable(level_out))
      else $error("set-level did not hold its level");
   timed_span_a: assert property (
      (state == eng_pkg::st_set || state == eng_pkg::st_wait) && tick &&
      cnt == 14'h0001 |-> elapsed + 14'h0001 == span &&
      (state != eng_pkg::st_set || span == eng_pkg::SET_TICKS))
      else $error("timed op ended after wrong tick count");
   rel_up_a: assert property (
      accept_set && !op_arg[eng_pkg::TYPE_BIT] && !op_arg[eng_pkg::SIGN_BIT]
      && active_mask[1] && op_cmd == eng_pkg::cmd_set_level &&
      ({1'b0, level_out[15:8]} + {1'b0, op_arg[7:0]}) < 9'h100
      |=> level_out[15:8] == $past(level_out[15:8]) + $past(op_arg[7:0]))
      else $error("relative increase wrong");
   rel_down_a: assert property (
      accept_set && !op_arg[eng_pkg::TYPE_BIT] && op_arg[eng_pkg::SIGN_BIT]
      && active_mask[1] && op_cmd == eng_pkg::cmd_set_level &&
      level_out[15:8] >= op_arg[7:0]
      |=> level_out[15:8] == $past(level_out[15:8]) - $past(op_arg[7:0]))
      else $error("relative decrease wrong");
   sat_high_a: assert property (
      accept_set && !op_arg[eng_pkg::TYPE_BIT] && !op_arg[eng_pkg::SIGN_BIT]
      && active_mask[1] &&
      ({1'b0, level_out[15:8]} + {1'b0, lv.value}) > 9'h0FF
      |=> level_out[15:8] == eng_pkg::LVL_MAX)
      else $error("relative increase did not saturate");
   var_src_a: assert property (
      accept_set && op_cmd == eng_pkg::cmd_set_var &&
      op_arg[eng_pkg::TYPE_BIT] && op_arg[1:0] == 2'h2 && active_mask[1]
      |=> level_out[15:8] == $past(var_c))
      else $error("variable source not honoured");
   wait_freeze_a: assert property (
      state == eng_pkg::st_wait |=> $stable(level_out))
      else $error("levels moved during wait");
   wait_len_a: assert property (
      accept && op_cmd == eng_pkg::cmd_wait && op_arg[eng_pkg::WAIT_PRE_BIT]
      && op_arg[13:9] != 5'h00
      |=> cnt == {$past(op_arg[13:9]), 9'h000} && waiting)
      else $error("slow wait length wrong");
   row_load_a: assert property (
      state == eng_pkg::st_fetch && mem_rd |=>
      state == eng_pkg::st_load ##1 active_mask == $past(mem_data[N-1:0]))
      else $error("mapping row not loaded");
   map_quiet_a: assert property (
      accept && !accept_set && op_cmd != eng_pkg::cmd_wait
      |=> $stable(level_out) ##1 (!busy || $stable(level_out)))
      else $error("mapping op changed a level");
   bound_rec_a: assert property (
      accept && op_cmd == eng_pkg::table_last_op
      |=> table_last == $past(op_arg[A-1:0]))
      else $error("table end not recorded");
   one_hot_a: assert property (
      accept && op_cmd == eng_pkg::cmd_select |=> $onehot0(active_mask))
      else $error("select mapped more than one output");
   clear_all_a: assert property (
      accept && op_cmd == eng_pkg::cmd_clear
      |=> active_mask == '0 && $stable(level_out))
      else $error("clear did not detach outputs");
   fwd_wrap_a: assert property (
      accept && op_cmd == eng_pkg::cmd_step_fwd && row_ptr == table_last
      |=> row_ptr == table_first ##0 mem_rd)
      else $error("step forward did not wrap");
   back_wrap_a: assert property (
      accept && op_cmd == eng_pkg::cmd_step_back && row_ptr == table_first
      |=> row_ptr == table_last ##0 mem_rd)
      else $error("step back did not wrap");
   set_row_a: assert property (
      accept && op_cmd == eng_pkg::cmd_set_row
      |=> mem_addr == $past(op_arg[A-1:0]) && mem_rd)
      else $error("set-row pointer wrong");
   unmapped_a: assert property (
      accept_set && !active_mask[1] |=> $stable(level_out[15:8]))
      else $error("unmapped output changed");

   set_seen_c:  cover property (accept_set ##1 busy);
   wait_done_c: cover property (state == eng_pkg::st_wait && tick &&
                                cnt == 14'h0001);
   wrap_c:      cover property (accept && op_cmd == eng_pkg::cmd_step_fwd
                                && row_ptr == table_last);
   load_c:      cover property (state == eng_pkg::st_load &&
                                mem_data[N-1:0] != '0);
endmodule

// ==== dv/prog_mem_model.sv ====
`timescale 1ns/10ps
// Program memory seen by the engine, holding a three-row mapping table
module prog_mem_model #(
   parameter logic [6:0]  BASE  = 7'h0A,
   parameter logic [15:0] ROW_0 = 16'h0000,
   parameter logic [15:0] ROW_1 = 16'h0000,
   parameter logic [15:0] ROW_2 = 16'h0000
) (
   input  wire logic        sys_clk,
   input  wire logic        mem_rd,
   input  wire logic [6:0]  mem_addr,
   output logic      [15:0] mem_data
);
   logic [15:0] row;

   // Table may sit anywhere; one 16-bit word per row
   always_comb begin
      if (mem_addr == BASE)
         row = ROW_0;
      else if (mem_addr == BASE + 7'h01)
         row = ROW_1;
      else if (mem_addr == BASE + 7'h02)
         row = ROW_2;
      else
         row = {9'h155, mem_addr};
   end

   // Data valid only the cycle after the strobe; the bus toggles
   // otherwise so that a late sample cannot look right by luck
   always @(posedge sys_clk) begin
      if (mem_rd)
         mem_data <= row;
      else
         mem_data <= ~mem_data;
   end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   localparam logic [15:0] ROW_0 = 16'hF105;
   localparam logic [15:0] ROW_1 = 16'h06AA;
   localparam logic [15:0] ROW_2 = 16'h0406;
   localparam logic [6:0]  TBL_BASE = 7'h0A;
   localparam logic [6:0]  TBL_END  = 7'h0C;
   localparam int          SET_LEN  = 16 * eng_pkg::MASTER_DIV;

   logic          sys_clk;
   logic          rst;
   logic          op_valid;
   eng_pkg::cmd_t op_cmd;
   logic [15:0]   op_arg;
   logic [7:0]    var_a;
   logic [7:0]    var_b;
   logic [7:0]    var_c;
   logic [7:0]    var_d;
   logic [15:0]   mem_data;
   logic [6:0]    mem_addr;
   logic          mem_rd;
   logic          busy;
   logic          waiting;
   logic [10:0]   active_mask;
   logic [6:0]    table_first;
   logic [6:0]    table_last;
   logic [87:0]   level_out;
   int            err_count;
   int            tests_run;
   int            lvl[11];
   int            n;
   int            val;
   logic [10:0]   mdl_mask;
   logic [31:0]   seed;
   logic [31:0]   r;
   logic [15:0]   arg;
   logic [7:0]    v;

   engine_brightness_and_mapping engine_brightness_and_mapping_i (
      .sys_clk(sys_clk), .rst(rst), .op_valid(op_valid),
      .op_cmd(op_cmd), .op_arg(op_arg), .var_a(var_a), .var_b(var_b),
      .var_c(var_c), .var_d(var_d), .mem_data(mem_data),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .busy(busy),
      .waiting(waiting), .active_mask(active_mask),
      .table_first(table_first), .table_last(table_last),
      .level_out(level_out));

   prog_mem_model #(.BASE(TBL_BASE), .ROW_0(ROW_0), .ROW_1(ROW_1),
                    .ROW_2(ROW_2)) prog_mem_model_i (
      .sys_clk(sys_clk), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_data(mem_data));

   always #4 sys_clk = ~sys_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Reference for one set: absolute load or saturating step
   function automatic void mdl_set(logic abs_t, logic dec, int d);
      for (int i = 0; i < 11; i++) begin
         if (mdl_mask[i]) begin
            if (abs_t)
               lvl[i] = d;
            else if (dec)
               lvl[i] = (lvl[i] < d) ? 0 : lvl[i] - d;
            else
               lvl[i] = (lvl[i] + d > 255) ? 255 : lvl[i] + d;
         end
      end
   endfunction

   function automatic logic [10:0] sel_mask(int s);
      return (s >= 1 && s <= 11) ? 11'(1 << (s - 1)) : 11'h000;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic chk_levels();
      for (int i = 0; i < 11; i++)
         chk({24'h0, level_out[8*i +: 8]}, lvl[i]);
   endtask

   // Callers stand on a falling edge; op_valid stays up for chaining
   task automatic issue(input eng_pkg::cmd_t c, input logic [15:0] a);
      op_valid = 1'b1;
      op_cmd = c;
      op_arg = a;
      @(negedge sys_clk);
   endtask

   task automatic idle();
      op_valid = 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      mdl_mask = 11'h000;
      foreach (lvl[i]) lvl[i] = 0;
   endtask

   // Pointer op: fetch, load, then the row becomes the mask
   task automatic do_step(input eng_pkg::cmd_t c, input logic [15:0] a,
                          input logic [6:0] ea, input logic [15:0] row);
      issue(c, a);
      chk({31'h0, mem_rd}, 32'h1);
      idle();
      n = 0;
      while (busy !== 1'b0 && n < 100) begin
         n++;
         @(negedge sys_clk);
      end
      mdl_mask = row[10:0];
      chk({25'h0, mem_addr}, {25'h0, ea});
      chk({21'h0, active_mask}, {21'h0, mdl_mask});
      chk_levels();
   endtask

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog sized for one full set plus short tests
   initial begin
      repeat (SET_LEN + 20000) @(posedge sys_clk);
      err_count++;
      end_of_test();
   end

   initial begin
      sys_clk = 1'b0;
      op_valid = 1'b0;
      op_cmd = eng_pkg::cmd_clear;
      op_arg = 16'h0000;
      {var_a, var_b, var_c, var_d} = 32'h0000_0000;
      err_count = 0;
      tests_run = 0;
      seed = 32'h0000_423B;
      do_reset();
      // Bounds back to back, then pointer moves with wrap
      issue(eng_pkg::table_first_op, {9'h000, TBL_BASE});
      issue(eng_pkg::table_last_op, {9'h000, TBL_END});
      idle();
      chk({25'h0, table_first}, {25'h0, TBL_BASE});
      chk({25'h0, table_last}, {25'h0, TBL_END});
      do_step(eng_pkg::cmd_set_row, 16'h0F8C, TBL_END, ROW_2);
      do_step(eng_pkg::cmd_step_fwd, 16'h0000, TBL_BASE, ROW_0);
      do_step(eng_pkg::cmd_step_back, 16'h0000, TBL_END, ROW_2);
      do_step(eng_pkg::cmd_step_back, 16'h0000, 7'h0B, ROW_1);
      // Full-length absolute set with a refused op during it
      arg = rnd();
      arg[15:14] = 2'b01;
      v = arg[7:0];
      issue(eng_pkg::cmd_set_level, arg);
      mdl_set(1'b1, 1'b0, v);
      chk_levels();
      chk({31'h0, busy}, 32'h1);
      issue(eng_pkg::cmd_select, 16'h0000);
      idle();
      n = 2;
      while (busy === 1'b1 && n < SET_LEN + 100) begin
         n++;
         @(negedge sys_clk);
      end
      chk({31'h0, n >= SET_LEN - 8 && n <= SET_LEN + 8}, 32'h1);
      chk({21'h0, active_mask}, {21'h0, ROW_1[10:0]});
      // Clear keeps levels; pointer survives it
      issue(eng_pkg::cmd_clear, 16'h0000);
      idle();
      mdl_mask = 11'h000;
      chk({21'h0, active_mask}, 32'h0);
      chk_levels();
      do_step(eng_pkg::cmd_step_fwd, 16'h0000, TBL_END, ROW_2);
      // Relative decrease: overlap rows fall, the rest clamp at zero
      issue(eng_pkg::cmd_set_level, {8'h01, v >> 1});
      mdl_set(1'b0, 1'b1, v >> 1);
      chk_levels();
      idle();
      // Waits of both prescales refuse a set and freeze levels
      for (int p = 0; p < 2; p++) begin
         do_reset();
         issue(eng_pkg::cmd_select, 16'h000B);
         idle();
         mdl_mask = 11'h400;
         r = rnd() % 31;
         issue(eng_pkg::cmd_wait, {1'b0, p[0], r[4:0] + 5'h01, 9'h000});
         issue(eng_pkg::cmd_set_level, 16'h40FF);
         idle();
         repeat (1000) @(negedge sys_clk);
         chk({31'h0, waiting}, 32'h1);
         // No tick has come yet, so the loaded length is still whole
         chk({18'h0, engine_brightness_and_mapping_i.cnt},
             (r + 1) * (p ? 512 : 16));
         chk_levels();
      end
      do_reset();
      // Every selector code
      for (int s = 0; s < 16; s++) begin
         issue(eng_pkg::cmd_select, 16'(s));
         idle();
         chk({21'h0, active_mask}, {21'h0, sel_mask(s)});
      end
      // Random sets from reset; odd passes use each variable source;
      // early passes map output two so its level checks get exercised
      for (int k = 0; k < 8; k++) begin
         do_reset();
         r = rnd();
         if (k < 6) r[19:16] = 4'h2;
         {var_a, var_b, var_c, var_d} = rnd();
         mdl_mask = sel_mask(r[19:16]);
         issue(eng_pkg::cmd_select, {12'h000, r[19:16]});
         idle();
         arg = {1'b0, r[14:0]};
         if (k == 0) {arg[14], arg[8]} = 2'b00;
         if (k == 5) arg[14] = 1'b1;
         if (k % 2 == 1)
            arg[1:0] = 2'(k / 2);
         val = arg[7:0];
         if (k % 2 == 1)
            case (arg[1:0])
               2'b00: val = var_a;
               2'b01: val = var_b;
               2'b10: val = var_c;
               default: val = var_d;
            endcase
         issue((k % 2 == 1) ? eng_pkg::cmd_set_var
                            : eng_pkg::cmd_set_level, arg);
         mdl_set(arg[14], arg[8], val);
         chk_levels();
         idle();
      end
      end_of_test();
   end
endmodule
